// File: inc/asapu_pkg.sv
// constants shared by the abort status and protection unit
package asapu_pkg;
	// register byte offsets on the wishbone slave
	localparam logic [7:0] OFF_PU_ENABLE = 8'h00;
	localparam logic [7:0] OFF_PERIPH_PERIPHERAL_PROTECTION_FIELD = 8'h04;
	localparam logic [7:0] OFF_ABORT_ADDR = 8'h08;
	localparam logic [7:0] OFF_ABORT_STATUS = 8'h0C;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
	localparam logic [7:0] OFF_REGION_BASE = 8'h40;
	localparam logic [7:0] OFF_REGION_LAST = 8'h7C;
	localparam int NUM_REGIONS = 16;

	// region configuration word layout
	localparam int RC_EN = 0;
	localparam int RC_SIZE_LO = 1;
	localparam int RC_WPROT = 5;
	localparam int RC_UPROT = 6;
	localparam int RC_MSEL = 7;
	localparam logic [3:0] RC_SIZE_MAX = 4'hC;
	localparam logic [31:0] RC_MIN_MASK = 32'hFFFF_FC00;

	// peripheral protection field layout
	localparam int PP_WPROT = 0;
	localparam int PP_UPROT = 1;
	localparam int PP_MSEL = 2;

	// abort status word layout
	localparam int AS_SIZE_LO = 0;
	localparam int AS_TYPE_LO = 8;
	localparam int AS_UNDEF = 10;
	localparam int AS_MISAL = 11;
	localparam int AS_PERIPHERAL_PROTECTION_FIELD = 12;
	localparam int AS_MST_LO = 16;
	localparam int AS_SEEN_LO = 24;

	// interrupt status bits
	localparam int IRQ_ABORT = 0;
	localparam int IRQ_OVERRUN = 1;

	// access sizes and types
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_HALF = 2'h1;
	localparam logic [1:0] SZ_WORD = 2'h2;
	localparam logic [1:0] TY_DREAD = 2'h0;
	localparam logic [1:0] TY_DWRITE = 2'h1;
	localparam logic [1:0] TY_FETCH = 2'h2;

	// reset values
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic RST_PU_EN = 1'b0;
endpackage

// File: rtl/asapu_region_match.sv
// one protected region: does an address fall inside it
`timescale 1ns/1ps
module asapu_region_match (
	// region configuration word
	input wire logic [31:0] cfg_i,
	// address under test
	input wire logic [31:0] addr_i,
	// match result
	output logic hit_o
);
	logic [3:0] size_code;
	logic [31:0] mask;

	// size codes past the largest region clamp to it rather than alias small sizes
	// power of two
	always_comb begin
		size_code = cfg_i[asapu_pkg::RC_SIZE_LO +: 4];
		if (size_code > asapu_pkg::RC_SIZE_MAX) begin
			size_code = asapu_pkg::RC_SIZE_MAX;
		end
		mask = asapu_pkg::RC_MIN_MASK << size_code;
	end

	assign hit_o = cfg_i[asapu_pkg::RC_EN] && (((addr_i ^ cfg_i) & mask) == 32'h0000_0000);
endmodule

// File: rtl/asapu_top.sv
// abort detection, abort status record and memory protection unit
`timescale 1ns/1ps
module asapu_top #(
	parameter logic [31:0] INT_MEM_TOP = 32'h0040_0000,
	parameter logic [31:0] PERIPH_BASE = 32'hFFF0_0000
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// observed system bus access
	input wire logic acc_valid_i,
	input wire logic [31:0] acc_addr_i,
	input wire logic [1:0] acc_size_i,
	input wire logic [1:0] acc_type_i,
	input wire logic [1:0] acc_master_i,
	input wire logic acc_priv_i,
	// abort to each master and interrupt
	output logic abort_m0_o,
	output logic abort_m1_o,
	output logic irq_o
);
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic pu_en;
		logic [2:0] pprot;
		logic [asapu_pkg::NUM_REGIONS-1:0][31:0] rcfg;
		logic [31:0] ab_addr;
		logic [1:0] ab_size;
		logic [1:0] ab_type;
		logic [2:0] ab_cause;
		logic [1:0] ab_mst;
		logic [1:0] seen;
		logic rec_valid;
		logic abort;
		logic [1:0] irq_st;
		logic [1:0] irq_mask;
		logic irq;
	} asapu_state_s;

	asapu_state_s st_r;
	asapu_state_s st_nxt;

	logic [asapu_pkg::NUM_REGIONS-1:0] reg_hit;
	logic [asapu_pkg::NUM_REGIONS-1:0] reg_viol;
	logic in_mem;
	logic in_periph;
	logic is_write;
	logic undef_c;
	logic misal_c;
	logic peripheral_protection_field_c;
	logic periph_viol;
	logic take_abort;
	logic bus_req;
	logic do_wr;
	logic do_rd;
	logic [31:0] status_word;

	// merge write data into a register under the byte enables
	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return res;
	endfunction

	// is one area protected against this access
	function automatic logic area_forbids(input logic wprot, input logic uprot,
		input logic msel, input logic wr, input logic priv, input logic [1:0] mst);
		return (mst == {1'b0, msel}) && ((wprot && wr) || (uprot && !priv));
	endfunction

	for (genvar g = 0; g < asapu_pkg::NUM_REGIONS; g++) begin : g_region
		asapu_region_match u_match (
			.cfg_i(st_r.rcfg[g]),
			.addr_i(acc_addr_i),
			.hit_o(reg_hit[g])
		);
		assign reg_viol[g] = reg_hit[g] && area_forbids(st_r.rcfg[g][asapu_pkg::RC_WPROT],
			st_r.rcfg[g][asapu_pkg::RC_UPROT], st_r.rcfg[g][asapu_pkg::RC_MSEL],
			is_write, acc_priv_i, acc_master_i);
	end

	// address space decode and misalignment
	assign in_mem = acc_addr_i < INT_MEM_TOP;
	assign in_periph = acc_addr_i >= PERIPH_BASE;
	assign is_write = acc_type_i == asapu_pkg::TY_DWRITE;
	assign undef_c = !(in_mem || in_periph);
	assign misal_c = ((acc_size_i == asapu_pkg::SZ_HALF) && acc_addr_i[0]) ||
		((acc_size_i == asapu_pkg::SZ_WORD) && (acc_addr_i[1:0] != 2'h0));

	assign periph_viol = in_periph && area_forbids(st_r.pprot[asapu_pkg::PP_WPROT],
		st_r.pprot[asapu_pkg::PP_UPROT], st_r.pprot[asapu_pkg::PP_MSEL],
		is_write, acc_priv_i, acc_master_i);

	assign peripheral_protection_field_c = st_r.pu_en && ((in_mem && (|reg_viol)) || periph_viol);

	assign take_abort = acc_valid_i && (undef_c || misal_c || peripheral_protection_field_c);

	// bus handshake: answer one cycle after the request, drop ack the cycle after
	assign bus_req = wb_cyc_i && wb_stb_i && !st_r.ack;
	assign do_wr = bus_req && wb_we_i;
	assign do_rd = bus_req && !wb_we_i;

	// abort status word as software sees it
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[asapu_pkg::AS_SIZE_LO +: 2] = st_r.ab_size;
		status_word[asapu_pkg::AS_TYPE_LO +: 2] = st_r.ab_type;
		status_word[asapu_pkg::AS_UNDEF] = st_r.ab_cause[0];
		status_word[asapu_pkg::AS_MISAL] = st_r.ab_cause[1];
		status_word[asapu_pkg::AS_PERIPHERAL_PROTECTION_FIELD] = st_r.ab_cause[2];
		status_word[asapu_pkg::AS_MST_LO +: 2] = st_r.ab_mst;
		status_word[asapu_pkg::AS_SEEN_LO +: 2] = st_r.seen;
	end

	// next state of the whole block
	always_comb begin
		st_nxt = st_r;
		st_nxt.ack = bus_req;
		st_nxt.abort = take_abort;
		// register writes; read-only words ignore them
		if (do_wr) begin
			if (wb_adr_i == asapu_pkg::OFF_PU_ENABLE) begin
				if (wb_sel_i[0]) begin
					st_nxt.pu_en = wb_dat_i[0];
				end
			end else if (wb_adr_i == asapu_pkg::OFF_PERIPH_PERIPHERAL_PROTECTION_FIELD) begin
				if (wb_sel_i[0]) begin
					st_nxt.pprot = wb_dat_i[2:0];
				end
			end else if (wb_adr_i == asapu_pkg::OFF_IRQ_STATUS) begin
				if (wb_sel_i[0]) begin
					st_nxt.irq_st = st_r.irq_st & ~wb_dat_i[1:0];
				end
			end else if (wb_adr_i == asapu_pkg::OFF_IRQ_MASK) begin
				if (wb_sel_i[0]) begin
					st_nxt.irq_mask = wb_dat_i[1:0];
				end
			end else if (wb_adr_i >= asapu_pkg::OFF_REGION_BASE &&
				wb_adr_i <= asapu_pkg::OFF_REGION_LAST && wb_adr_i[1:0] == 2'h0) begin
				st_nxt.rcfg[wb_adr_i[5:2]] = be_merge(st_r.rcfg[wb_adr_i[5:2]], wb_dat_i,
					wb_sel_i);
			end
		end
		// reading the abort status clears the per-master flags
		if (do_rd && wb_adr_i == asapu_pkg::OFF_ABORT_STATUS) begin
			st_nxt.seen = 2'h0;
			st_nxt.rec_valid = 1'b0;
		end
		// an abort in the clearing cycle still lands: set wins over clear
		if (take_abort) begin
			if (st_r.rec_valid && !st_r.ab_mst[1]) begin
				st_nxt.seen[st_r.ab_mst[0]] = 1'b1;
			end
			if (st_r.rec_valid) begin
				st_nxt.irq_st[asapu_pkg::IRQ_OVERRUN] = 1'b1;
			end
			st_nxt.ab_addr = acc_addr_i;
			st_nxt.ab_size = acc_size_i;
			st_nxt.ab_type = acc_type_i;
			st_nxt.ab_cause = {peripheral_protection_field_c, misal_c, undef_c};
			st_nxt.ab_mst = acc_master_i;
			st_nxt.rec_valid = 1'b1;
			st_nxt.irq_st[asapu_pkg::IRQ_ABORT] = 1'b1;
		end
		// read data, unmapped words answer zero
		st_nxt.rdata = 32'h0000_0000;
		if (do_rd) begin
			if (wb_adr_i == asapu_pkg::OFF_PU_ENABLE) begin
				st_nxt.rdata = {31'h0000_0000, st_r.pu_en};
			end else if (wb_adr_i == asapu_pkg::OFF_PERIPH_PERIPHERAL_PROTECTION_FIELD) begin
				st_nxt.rdata = {29'h0000_0000, st_r.pprot};
			end else if (wb_adr_i == asapu_pkg::OFF_ABORT_ADDR) begin
				st_nxt.rdata = st_r.ab_addr;
			end else if (wb_adr_i == asapu_pkg::OFF_ABORT_STATUS) begin
				st_nxt.rdata = status_word;
			end else if (wb_adr_i == asapu_pkg::OFF_IRQ_STATUS) begin
				st_nxt.rdata = {30'h0000_0000, st_r.irq_st};
			end else if (wb_adr_i == asapu_pkg::OFF_IRQ_MASK) begin
				st_nxt.rdata = {30'h0000_0000, st_r.irq_mask};
			end else if (wb_adr_i >= asapu_pkg::OFF_REGION_BASE &&
				wb_adr_i <= asapu_pkg::OFF_REGION_LAST && wb_adr_i[1:0] == 2'h0) begin
				st_nxt.rdata = st_r.rcfg[wb_adr_i[5:2]];
			end
		end
		// level interrupt follows the next status and mask so it stays a flop output
		st_nxt.irq = |(st_nxt.irq_st & st_nxt.irq_mask);
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= '0;
			st_r.pu_en <= asapu_pkg::RST_PU_EN;
			st_r.ab_addr <= asapu_pkg::RST_WORD;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign abort_m0_o = st_r.abort;
	assign abort_m1_o = st_r.abort;
	assign wb_ack_o = st_r.ack;
	assign wb_dat_o = st_r.rdata;
	assign irq_o = st_r.irq;

	// checks on the block's own behaviour
	sequence s_fault;
		acc_valid_i && (undef_c || misal_c || peripheral_protection_field_c);
	endsequence

	sequence s_overrun;
		s_fault ##0 (st_r.rec_valid && !st_r.ab_mst[1]);
	endsequence

	property p_abort_cause;
		@(posedge clk_i) disable iff (rst_i)
		abort_m0_o |-> $past(acc_valid_i) && (st_r.ab_cause != 3'h0);
	endproperty
	a_abort_cause: assert property (p_abort_cause) else $error("abort without cause");

	property p_abort_follows;
		@(posedge clk_i) disable iff (rst_i)
		s_fault |=> abort_m0_o ##1 (abort_m0_o == $past(take_abort));
	endproperty
	a_abort_follows: assert property (p_abort_follows) else $error("fault not aborted");

	property p_broadcast;
		@(posedge clk_i) disable iff (rst_i)
		abort_m0_o == abort_m1_o;
	endproperty
	a_broadcast: assert property (p_broadcast) else $error("abort not broadcast");

	property p_addr_capture;
		@(posedge clk_i) disable iff (rst_i)
		s_fault |=> st_r.ab_addr == $past(acc_addr_i);
	endproperty
	a_addr_capture: assert property (p_addr_capture) else $error("address not captured");

	property p_size_type;
		@(posedge clk_i) disable iff (rst_i)
		s_fault |=> st_r.ab_size == $past(acc_size_i) && st_r.ab_type == $past(acc_type_i);
	endproperty
	a_size_type: assert property (p_size_type) else $error("size or type wrong");

	property p_misal_bit;
		@(posedge clk_i) disable iff (rst_i)
		(acc_valid_i && acc_size_i == asapu_pkg::SZ_WORD && acc_addr_i[1:0] == 2'h2)
			|=> abort_m0_o && st_r.ab_cause[1];
	endproperty
	a_misal_bit: assert property (p_misal_bit) else $error("misaligned not flagged");

	property p_master_id;
		@(posedge clk_i) disable iff (rst_i)
		s_fault |=> st_r.ab_mst == $past(acc_master_i) ##1 (!abort_m0_o ||
			st_r.ab_mst == $past(acc_master_i));
	endproperty
	a_master_id: assert property (p_master_id) else $error("master id wrong");

	property p_seen;
		@(posedge clk_i) disable iff (rst_i)
		s_overrun |=> st_r.seen[$past(st_r.ab_mst[0])];
	endproperty
	a_seen: assert property (p_seen) else $error("overwritten abort not flagged");

	property p_pu_off;
		@(posedge clk_i) disable iff (rst_i)
		(s_fault ##0 !st_r.pu_en) |=> !st_r.ab_cause[2];
	endproperty
	a_pu_off: assert property (p_pu_off) else $error("protection while disabled");

	property p_ack_once;
		@(posedge clk_i) disable iff (rst_i)
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("bus ack timing wrong");

	property p_peripheral_protection_field_abort;
		@(posedge clk_i) disable iff (rst_i)
		(acc_valid_i && peripheral_protection_field_c) |=> abort_m0_o && st_r.ab_cause[2];
	endproperty
	a_peripheral_protection_field_abort: assert property (p_peripheral_protection_field_abort) else $error("violation not aborted");

	property p_undef_bit;
		@(posedge clk_i) disable iff (rst_i)
		(acc_valid_i && (acc_addr_i >= INT_MEM_TOP) && (acc_addr_i < PERIPH_BASE))
			|=> abort_m0_o && st_r.ab_cause[0];
	endproperty
	a_undef_bit: assert property (p_undef_bit) else $error("undefined not flagged");

	// a lagging interrupt would miss the edge software waits for
	property p_irq_level;
		@(posedge clk_i) disable iff (rst_i)
		irq_o == (|(st_r.irq_st & st_r.irq_mask));
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");
endmodule

// File: tb/asapu_bus_masters.sv
// partner model: processor core and dma master presenting accesses
`timescale 1ns/1ps
module asapu_bus_masters (
	// clock
	input wire logic clk_i,
	// aborts returned by the unit
	input wire logic abort_m0_i,
	input wire logic abort_m1_i,
	// access presented to the unit
	output logic acc_valid_o,
	output logic [31:0] acc_addr_o,
	output logic [1:0] acc_size_o,
	output logic [1:0] acc_type_o,
	output logic [1:0] acc_master_o,
	output logic acc_priv_o
);
	// quiet bus at time zero
	initial begin
		acc_valid_o = 1'b0;
		acc_addr_o = 32'h0000_0000;
		acc_size_o = 2'h0;
		acc_type_o = 2'h0;
		acc_master_o = 2'h0;
		acc_priv_o = 1'b0;
	end

	// one access, held one cycle; abort is sampled once the taking edge has landed
	task automatic issue(input logic [31:0] a, input logic [1:0] sz, ty, m, input logic p,
		output logic ab0, ab1, core_took);
		@(posedge clk_i);
		acc_valid_o <= 1'b1;
		acc_addr_o <= a;
		acc_size_o <= sz;
		acc_type_o <= ty;
		acc_master_o <= m;
		acc_priv_o <= p;
		@(posedge clk_i);
		acc_valid_o <= 1'b0;
		// released address lines must not keep the old value
		acc_addr_o <= ~a;
		#1;
		ab0 = abort_m0_i;
		ab1 = abort_m1_i;
		core_took = ab0 && (m == 2'h0);
	endtask
endmodule

// File: tb/abort_status_and_protection_unit_tb_top.sv
// self-checking bench for the abort status and protection unit
`timescale 1ns/1ps
module abort_status_and_protection_unit_tb_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_dat = 32'h0000_0000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, acc_valid, acc_priv, abort_m0, abort_m1, irq_o;
	logic [31:0] acc_addr;
	logic [1:0] acc_size, acc_type, acc_master;
	int fails = 0;
	int checked = 0;
	int cycles = 0;

	// 40 MHz clock
	always #12.5 clk_i = ~clk_i;

	asapu_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .acc_valid_i(acc_valid),
		.acc_addr_i(acc_addr), .acc_size_i(acc_size), .acc_type_i(acc_type),
		.acc_master_i(acc_master), .acc_priv_i(acc_priv), .abort_m0_o(abort_m0),
		.abort_m1_o(abort_m1), .irq_o(irq_o));

	asapu_bus_masters mm_u (.clk_i(clk_i), .abort_m0_i(abort_m0), .abort_m1_i(abort_m1),
		.acc_valid_o(acc_valid), .acc_addr_o(acc_addr), .acc_size_o(acc_size),
		.acc_type_o(acc_type), .acc_master_o(acc_master), .acc_priv_o(acc_priv));

	task automatic end_sim;
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// a hang anywhere counts as a mismatch
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			end_sim();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// classic wishbone cycle; request held until ack is sampled high
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_sel <= 4'hF;
		wb_dat <= d;
		@(posedge clk_i);
		// only the bench timeout ends this wait
		while (wb_ack_o !== 1'b1) begin
			@(posedge clk_i);
		end
		q = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		wb(1'b0, a, 32'h0000_0000, q);
		chk(q, exp);
	endtask

	// one access; both masters see the same abort, only the core acts on it
	task automatic acc(input logic [31:0] a, input logic [1:0] sz, ty, m, input logic p,
		input logic exp);
		logic ab0, ab1, took;
		mm_u.issue(a, sz, ty, m, p, ab0, ab1, took);
		chk({29'h0, ab0, ab1, took}, {29'h0, exp, exp, exp && (m == 2'h0)});
	endtask

	// expected abort status word from its fields
	function automatic logic [31:0] stw(input logic [1:0] sz, ty, input logic [2:0] cause,
		input logic [1:0] m, sv);
		stw = (32'(sz) << asapu_pkg::AS_SIZE_LO) | (32'(ty) << asapu_pkg::AS_TYPE_LO)
			| (32'(cause) << asapu_pkg::AS_UNDEF) | (32'(m) << asapu_pkg::AS_MST_LO)
			| (32'(sv) << asapu_pkg::AS_SEEN_LO);
	endfunction

	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(asapu_pkg::OFF_ABORT_STATUS, 32'h0000_0000);
		rd(asapu_pkg::OFF_PU_ENABLE, 32'h0000_0000);
		rd(8'h20, 32'h0000_0000);
		wr(asapu_pkg::OFF_IRQ_MASK, 32'h0000_0001);
		// undefined address, data read by the core
		acc(32'h1000_0000, asapu_pkg::SZ_WORD, asapu_pkg::TY_DREAD, 2'h0, 1'b1, 1'b1);
		chk({31'h0, irq_o}, 32'h0000_0001);
		rd(asapu_pkg::OFF_ABORT_ADDR, 32'h1000_0000);
		rd(asapu_pkg::OFF_ABORT_STATUS, stw(2'h2, 2'h0, 3'h1, 2'h0, 2'h0));
		wr(asapu_pkg::OFF_IRQ_STATUS, 32'h0000_0001);
		@(posedge clk_i);
		#1;
		chk({31'h0, irq_o}, 32'h0000_0000);
		// misaligned half write and misaligned word read by dma, then an aligned fetch that must pass
		acc(32'h0000_0101, asapu_pkg::SZ_HALF, asapu_pkg::TY_DWRITE, 2'h1, 1'b1, 1'b1);
		acc(32'h0000_0202, asapu_pkg::SZ_WORD, asapu_pkg::TY_DREAD, 2'h1, 1'b1, 1'b1);
		acc(32'h0000_0104, asapu_pkg::SZ_WORD, asapu_pkg::TY_FETCH, 2'h0, 1'b1, 1'b0);
		// region 0: 1K at zero, write protected for the core
		wr(asapu_pkg::OFF_REGION_BASE, 32'h0000_0021);
		acc(32'h0000_0010, asapu_pkg::SZ_WORD, asapu_pkg::TY_DWRITE, 2'h0, 1'b1, 1'b0);
		wr(asapu_pkg::OFF_PU_ENABLE, 32'h0000_0001);
		acc(32'h0000_0010, asapu_pkg::SZ_WORD, asapu_pkg::TY_DREAD, 2'h0, 1'b1, 1'b0);
		acc(32'h0000_0400, asapu_pkg::SZ_WORD, asapu_pkg::TY_DWRITE, 2'h0, 1'b1, 1'b0);
		acc(32'h0000_0010, asapu_pkg::SZ_WORD, asapu_pkg::TY_DWRITE, 2'h1, 1'b1, 1'b0);
		acc(32'h0000_0010, asapu_pkg::SZ_WORD, asapu_pkg::TY_DWRITE, 2'h0, 1'b1, 1'b1);
		rd(asapu_pkg::OFF_ABORT_ADDR, 32'h0000_0010);
		// unread dma record was overwritten, so its seen flag is up
		rd(asapu_pkg::OFF_ABORT_STATUS, stw(2'h2, 2'h1, 3'h4, 2'h0, 2'h2));
		rd(asapu_pkg::OFF_ABORT_STATUS, stw(2'h2, 2'h1, 3'h4, 2'h0, 2'h0));
		// region 15: 4M, user protected for dma
		wr(asapu_pkg::OFF_REGION_LAST, 32'h0000_00D9);
		acc(32'h0030_0000, asapu_pkg::SZ_HALF, asapu_pkg::TY_DREAD, 2'h1, 1'b0, 1'b1);
		acc(32'h0030_0000, asapu_pkg::SZ_HALF, asapu_pkg::TY_DREAD, 2'h1, 1'b1, 1'b0);
		// peripheral space user protected for the core
		wr(asapu_pkg::OFF_PERIPH_PERIPHERAL_PROTECTION_FIELD, 32'h0000_0002);
		acc(32'hFFF0_0000, asapu_pkg::SZ_BYTE, asapu_pkg::TY_DREAD, 2'h0, 1'b0, 1'b1);
		acc(32'hFFF0_0000, asapu_pkg::SZ_BYTE, asapu_pkg::TY_DREAD, 2'h0, 1'b1, 1'b0);
		rd(asapu_pkg::OFF_ABORT_STATUS, stw(2'h0, 2'h0, 3'h4, 2'h0, 2'h2));
		end_sim();
	end
endmodule
